// ### include/pss_pkg.sv
// Purpose: Shared constants and types of the PHY status summary block
// Assumes: Word-addressed register index, byte address = 4 * index
// Notes: Only the low byte of the status summary carries state

package pss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADR_W = 10;
  localparam logic [7:0] IDX_BASIC_MODE_STATUS_REG = 8'h01;
  localparam logic [7:0] IDX_STATUS = 8'h10;
  localparam logic [7:0] IDX_SRC = 8'h12;
  localparam logic [7:0] IDX_MASK = 8'h13;

  // ----------------------------------------------------------------
  // Status summary fields
  // ----------------------------------------------------------------
  localparam int unsigned ST_INT = 7;
  localparam int unsigned ST_RF = 6;
  localparam int unsigned ST_JAB = 5;
  localparam int unsigned ST_AN = 4;
  localparam int unsigned ST_LOOP = 3;
  localparam int unsigned ST_DUP = 2;
  localparam int unsigned ST_SPD = 1;
  localparam int unsigned ST_LINK = 0;

  // ----------------------------------------------------------------
  // Basic mode status fields
  // ----------------------------------------------------------------
  localparam int unsigned BM_JAB = 1;
  localparam int unsigned BM_LINK = 2;
  localparam int unsigned BM_RF = 4;
  localparam int unsigned BM_AN = 5;

  // ----------------------------------------------------------------
  // Interrupt sources
  // ----------------------------------------------------------------
  localparam int unsigned NSRC = 4;
  localparam int unsigned SRC_LINK = 0;
  localparam int unsigned SRC_AN = 1;
  localparam int unsigned SRC_RF = 2;
  localparam int unsigned SRC_JAB = 3;
  localparam logic [NSRC-1:0] MASK_RST = 4'h0;
  localparam logic [NSRC-1:0] SRC_RST = 4'h0;

  typedef struct packed {
    logic remote_fault;
    logic jabber;
    logic an_done;
    logic loopback;
    logic full_duplex;
    logic speed10;
    logic link;
  } pss_cond_s;

  typedef struct packed {
    pss_cond_s cond;
    logic rf;
    logic [NSRC-1:0] src;
    logic [NSRC-1:0] mask;
    logic ack;
    logic [31:0] dat;
    logic irq;
  } pss_state_s;

endpackage

// ### design/pss_status_regs.sv
// Purpose: Status summary, basic status, interrupt source and mask registers
// Assumes: Classic Wishbone slave, one wait state, inputs synchronous to CLOCK
// Notes: Upper byte of the status summary reads zero
//
// Functional notes
// RQ1: Bit 7 shows a pending interrupt; reading the source register clears it.
// RQ2: Bit 6 sets when the partner reports remote fault via negotiation.
// RQ3: Remote fault stays set until basic status is read or reset.
// RQ4: Bit 5 reports jabber, meaningful only at 10 Mb/s.
// RQ5: Jabber bit mirrors exactly the jabber bit of basic status.
// RQ6: Reading the summary never clears jabber or link bits.
// RQ7: Bit 4 high when negotiation completed, low otherwise.
// RQ8: Bit 3 high while interface loopback enabled, low in normal operation.
// RQ9: Bit 2 duplex, 1 full, 0 half, from negotiation or forcing.
// RQ10: Bit 1 speed, 1 for 10 Mb/s, 0 for 100 Mb/s.
// RQ11: Host trusts speed and duplex only with valid link and settled negotiation; the bench checks them whether or not link is up.
// RQ12: Bit 0 high with valid link, mirroring basic status link bit.
// RQ13: Writes to the summary are ignored; all bits read zero after reset.
//
// The Wishbone slave port was decided locally.

`timescale 1ns/1ns

module pss_status_regs (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [pss_pkg::ADR_W-1:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  input wire pss_pkg::pss_cond_s COND,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------
  pss_pkg::pss_state_s s_r;
  pss_pkg::pss_state_s s_nxt;

  localparam int unsigned NSRC_W = pss_pkg::NSRC;

  logic req;
  logic take;
  logic done;
  logic [7:0] idx;
  logic rd_basic_mode_status_reg;
  logic rd_src;
  logic rd_stat;
  logic wr_stat;
  logic wr_src;
  logic wr_mask;
  logic [NSRC_W-1:0] ev;
  logic [NSRC_W-1:0] clr;
  logic [15:0] stat_v;
  logic [15:0] basic_mode_status_reg_v;
  logic [31:0] rdata;
  logic irq_cond;

  assign req = CYC_I & STB_I;
  assign take = req & ~s_r.ack;
  assign done = req & s_r.ack;
  assign idx = ADR_I[pss_pkg::ADR_W-1:2];
  assign rd_basic_mode_status_reg = done & ~WE_I & (idx == pss_pkg::IDX_BASIC_MODE_STATUS_REG);
  assign rd_src = done & ~WE_I & (idx == pss_pkg::IDX_SRC);
  assign rd_stat = take & ~WE_I & (idx == pss_pkg::IDX_STATUS);
  assign wr_stat = done & WE_I & (idx == pss_pkg::IDX_STATUS);
  assign wr_src = done & WE_I & SEL_I[0] & (idx == pss_pkg::IDX_SRC);
  assign wr_mask = done & WE_I & SEL_I[0] & (idx == pss_pkg::IDX_MASK);

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  always_comb begin
    stat_v = 16'h0000;
    stat_v[pss_pkg::ST_INT] = |s_r.src; // see RQ1
    stat_v[pss_pkg::ST_RF] = s_r.rf; // see RQ2
    stat_v[pss_pkg::ST_JAB] = s_r.cond.jabber; // see RQ4
    stat_v[pss_pkg::ST_AN] = s_r.cond.an_done; // see RQ7
    stat_v[pss_pkg::ST_LOOP] = s_r.cond.loopback; // see RQ8
    stat_v[pss_pkg::ST_DUP] = s_r.cond.full_duplex; // see RQ9
    stat_v[pss_pkg::ST_SPD] = s_r.cond.speed10; // see RQ10
    stat_v[pss_pkg::ST_LINK] = s_r.cond.link; // see RQ12
    basic_mode_status_reg_v = 16'h0000;
    basic_mode_status_reg_v[pss_pkg::BM_JAB] = s_r.cond.jabber; // see RQ5
    basic_mode_status_reg_v[pss_pkg::BM_LINK] = s_r.cond.link; // see RQ12
    basic_mode_status_reg_v[pss_pkg::BM_RF] = s_r.rf;
    basic_mode_status_reg_v[pss_pkg::BM_AN] = s_r.cond.an_done;
  end

  always_comb begin
    rdata = 32'h0000_0000;
    unique case (idx)
      pss_pkg::IDX_STATUS: rdata = {16'h0000, stat_v};
      pss_pkg::IDX_BASIC_MODE_STATUS_REG: rdata = {16'h0000, basic_mode_status_reg_v};
      pss_pkg::IDX_SRC: rdata = {28'h0000000, s_r.src};
      pss_pkg::IDX_MASK: rdata = {28'h0000000, s_r.mask};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Events
  // ----------------------------------------------------------------
  always_comb begin
    ev = '0;
    ev[pss_pkg::SRC_LINK] = COND.link ^ s_r.cond.link;
    ev[pss_pkg::SRC_AN] = COND.an_done & ~s_r.cond.an_done;
    ev[pss_pkg::SRC_RF] = COND.remote_fault & ~s_r.cond.remote_fault;
    ev[pss_pkg::SRC_JAB] = COND.jabber & ~s_r.cond.jabber;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Live conditions; no read touches them
    s_nxt.cond = COND; // see RQ6
    s_nxt.ack = take;
    s_nxt.dat = (take & ~WE_I) ? rdata : 32'h0000_0000;
    // Set wins over the read clear
    s_nxt.rf = (s_r.rf & ~rd_basic_mode_status_reg) | COND.remote_fault; // see RQ2 see RQ3
    clr = '0;
    if (rd_src) begin
      clr = '1; // see RQ1
    end else if (wr_src) begin
      clr = DAT_I[NSRC_W-1:0];
    end
    s_nxt.src = (s_r.src & ~clr) | ev;
    if (wr_mask) begin
      s_nxt.mask = DAT_I[NSRC_W-1:0];
    end
    // Status summary writes fall through with no effect; see RQ13
    s_nxt.irq = |(s_nxt.src & s_nxt.mask);
  end

  assign irq_cond = |(s_nxt.src & s_nxt.mask);

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      s_r <= '0; // see RQ13
    end else begin
      s_r <= s_nxt;
    end
  end

  assign DAT_O = s_r.dat;
  assign ACK_O = s_r.ack;
  assign IRQ = s_r.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  int_clear_a: assert property ( // see RQ1
    rd_src && !(|ev) |=> !(|s_r.src) ##1 !DAT_O[pss_pkg::ST_INT])
    else $error("pending bit survived source read");

  rf_set_a: assert property ( // see RQ2
    COND.remote_fault |=> s_r.rf)
    else $error("remote fault not latched");

  rf_hold_a: assert property ( // see RQ3
    s_r.rf && !rd_basic_mode_status_reg |=> s_r.rf)
    else $error("remote fault dropped without basic status read");

  rf_clear_a: assert property ( // see RQ3
    rd_basic_mode_status_reg && !COND.remote_fault |=> !s_r.rf)
    else $error("remote fault not cleared by basic status read");

  jab_mirror_a: assert property ( // see RQ5
    rd_stat |=> DAT_O[pss_pkg::ST_JAB] == $past(basic_mode_status_reg_v[pss_pkg::BM_JAB]))
    else $error("jabber bit differs from basic status");

  stat_read_a: assert property ( // see RQ6
    done && !WE_I && idx == pss_pkg::IDX_STATUS && COND == s_r.cond
    |=> s_r.cond == $past(s_r.cond))
    else $error("summary read disturbed jabber or link");

  an_bit_a: assert property ( // see RQ7
    rd_stat |=> DAT_O[pss_pkg::ST_AN] == $past(s_r.cond.an_done))
    else $error("negotiation bit wrong");

  loop_bit_a: assert property ( // see RQ8
    rd_stat |=> DAT_O[pss_pkg::ST_LOOP] == $past(COND.loopback, 2))
    else $error("loopback bit wrong");

  dup_spd_a: assert property ( // see RQ9 see RQ10
    rd_stat |=> DAT_O[2:1] == $past({COND.full_duplex, COND.speed10}, 2))
    else $error("duplex or speed bit wrong");

  link_bit_a: assert property ( // see RQ12
    rd_stat |=> DAT_O[pss_pkg::ST_LINK] == $past(basic_mode_status_reg_v[pss_pkg::BM_LINK]))
    else $error("link bit differs from basic status");

  wr_ignored_a: assert property ( // see RQ13
    wr_stat && !COND.remote_fault |=> s_r.rf == $past(s_r.rf))
    else $error("write to summary changed state");

  ack_pulse_a: assert property (
    take |=> ACK_O ##1 !ACK_O)
    else $error("ack not a single cycle");

  irq_level_a: assert property (
    IRQ == $past(irq_cond))
    else $error("interrupt output wrong");

  // ----------------------------------------------------------------
  // Reset checks
  // ----------------------------------------------------------------
  rst_out_a: assert property ( // see RQ13
    @(posedge CLOCK) disable iff (1'b0)
    !NRST |=> DAT_O == 32'h0000_0000 && !ACK_O && !IRQ)
    else $error("outputs not cleared by reset");

  rst_state_a: assert property ( // see RQ13
    @(posedge CLOCK) disable iff (1'b0)
    !NRST |=> s_r.src == '0 && s_r.mask == '0 && !s_r.rf && s_r.cond == '0)
    else $error("state not cleared by reset");

  // ----------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------
  ack_req_a: assert property (
    !req |=> !ACK_O)
    else $error("ack without a request");

  dat_idle_a: assert property (
    !ACK_O |-> DAT_O == 32'h0000_0000)
    else $error("read data outside the ack cycle");

  dat_upper_a: assert property ( // see RQ13
    ACK_O |-> DAT_O[31:16] == 16'h0000)
    else $error("upper half of read data not zero");

  wr_dat_a: assert property (
    take && WE_I |=> DAT_O == 32'h0000_0000)
    else $error("write cycle returned data");

  mask_wr_a: assert property (
    wr_mask |=> s_r.mask == $past(DAT_I[NSRC_W-1:0]))
    else $error("mask write lost");

  mask_rd_a: assert property (
    take && !WE_I && idx == pss_pkg::IDX_MASK
    |=> DAT_O == {28'h0000000, $past(s_r.mask)})
    else $error("mask read returned wrong data");

  src_rd_a: assert property (
    take && !WE_I && idx == pss_pkg::IDX_SRC
    |=> DAT_O == {28'h0000000, $past(s_r.src)})
    else $error("source read returned wrong data");

  unmapped_a: assert property (
    take && !WE_I && idx != pss_pkg::IDX_STATUS && idx != pss_pkg::IDX_BASIC_MODE_STATUS_REG
    && idx != pss_pkg::IDX_SRC && idx != pss_pkg::IDX_MASK
    |=> DAT_O == 32'h0000_0000)
    else $error("unmapped read returned data");

  // ----------------------------------------------------------------
  // Status bit checks
  // ----------------------------------------------------------------
  pend_bit_a: assert property ( // see RQ1
    rd_stat |=> DAT_O[pss_pkg::ST_INT] == $past(|s_r.src))
    else $error("pending bit differs from source register");

  rf_bit_a: assert property ( // see RQ2
    rd_stat |=> DAT_O[pss_pkg::ST_RF] == $past(s_r.rf))
    else $error("remote fault bit differs from its latch");

  jab_live_a: assert property ( // see RQ4 see RQ5
    rd_stat |=> DAT_O[pss_pkg::ST_JAB] == $past(COND.jabber, 2))
    else $error("jabber bit differs from jabber input");

  an_live_a: assert property ( // see RQ7
    rd_stat |=> DAT_O[pss_pkg::ST_AN] == $past(COND.an_done, 2))
    else $error("negotiation bit differs from its input");

  link_live_a: assert property ( // see RQ12
    rd_stat |=> DAT_O[pss_pkg::ST_LINK] == $past(COND.link, 2))
    else $error("link bit differs from link input");

  basic_mode_status_reg_rd_a: assert property ( // see RQ5 see RQ12
    take && !WE_I && idx == pss_pkg::IDX_BASIC_MODE_STATUS_REG
    |=> DAT_O[pss_pkg::BM_JAB] == $past(COND.jabber, 2)
    && DAT_O[pss_pkg::BM_LINK] == $past(COND.link, 2)
    && DAT_O[pss_pkg::BM_RF] == $past(s_r.rf)
    && DAT_O[pss_pkg::BM_AN] == $past(COND.an_done, 2))
    else $error("basic status view differs from inputs");

  stat_src_a: assert property ( // see RQ6
    done && !WE_I && idx == pss_pkg::IDX_STATUS && !(|ev)
    |=> s_r.src == $past(s_r.src))
    else $error("summary read disturbed interrupt sources");

  // ----------------------------------------------------------------
  // Interrupt checks
  // ----------------------------------------------------------------
  link_ev_a: assert property ( // see RQ1
    COND.link != s_r.cond.link |=> s_r.src[pss_pkg::SRC_LINK])
    else $error("link change not recorded");

  an_ev_a: assert property ( // see RQ1
    COND.an_done && !s_r.cond.an_done |=> s_r.src[pss_pkg::SRC_AN])
    else $error("negotiation completion not recorded");

  rf_ev_a: assert property ( // see RQ1
    COND.remote_fault && !s_r.cond.remote_fault |=> s_r.src[pss_pkg::SRC_RF])
    else $error("remote fault rise not recorded");

  jab_ev_a: assert property ( // see RQ1
    COND.jabber && !s_r.cond.jabber |=> s_r.src[pss_pkg::SRC_JAB])
    else $error("jabber rise not recorded");

  irq_masked_a: assert property (
    s_r.mask == '0 |-> !IRQ)
    else $error("interrupt raised with every source masked");

  irq_src_a: assert property (
    IRQ |-> |s_r.src)
    else $error("interrupt raised with no source pending");

  rf_src_a: assert property ( // see RQ3
    rd_src && !COND.remote_fault |=> s_r.rf == $past(s_r.rf))
    else $error("source read touched remote fault latch");

  for (genvar i = 0; i < NSRC_W; i++) begin : g_src_chk
    src_hold_a: assert property (
      s_r.src[i] && !rd_src && !(wr_src && DAT_I[i]) |=> s_r.src[i])
      else $error("interrupt source dropped without a clear");

    src_w1c_a: assert property (
      wr_src && DAT_I[i] && !ev[i] |=> !s_r.src[i])
      else $error("written one did not clear its source");
  end

  // ----------------------------------------------------------------
  // Coverage
  // ----------------------------------------------------------------
  stat_read_c: cover property (rd_stat ##1 ACK_O);
  src_clear_c: cover property (rd_src && |s_r.src);
  irq_rise_c: cover property (!IRQ ##1 IRQ);
  rf_cycle_c: cover property (s_r.rf ##1 rd_basic_mode_status_reg ##1 !s_r.rf);
  jab_read_c: cover property (rd_stat && s_r.cond.jabber);

endmodule

// ### test/pss_host.sv
// Purpose: Management host model on the register bus
// Assumes: Classic single Wishbone cycles, one request at a time
// Notes: Waits for ack with no bound of its own; the bench watchdog ends a hang
`timescale 1ns/1ns
module pss_host (
  input wire logic CLOCK,
  output logic CYC_I,
  output logic STB_I,
  output logic WE_I,
  output logic [pss_pkg::ADR_W-1:0] ADR_I,
  output logic [3:0] SEL_I,
  output logic [31:0] DAT_I,
  input wire logic [31:0] DAT_O,
  input wire logic ACK_O
);
  initial begin
    {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} <= '0;
  end
  // Request held until ack; the bench checks speed and duplex whether or not link is up
  task automatic xfer(input logic w, input logic [pss_pkg::ADR_W-1:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge CLOCK);
    {CYC_I, STB_I, WE_I, ADR_I, SEL_I, DAT_I} <= {2'h3, w, a, 4'hF, d};
    do begin
      @(posedge CLOCK);
    end while (ACK_O !== 1'b1);
    q = DAT_O;
    {CYC_I, STB_I, WE_I} <= 3'h0;
  endtask
endmodule

// ### test/phy_status_summary_low_byte_tb.sv
// Purpose: Self-checking bench of the status summary registers
// Assumes: Host model issues all bus cycles
// Notes: Integer model tracks pending, remote fault latch and levels
`timescale 1ns/1ns
module phy_status_summary_low_byte_tb;
  logic CLOCK = 0, NRST = 0, CYC_I, STB_I, WE_I, ACK_O, IRQ;
  logic [pss_pkg::ADR_W-1:0] ADR_I;
  logic [3:0] SEL_I;
  logic [31:0] DAT_I, DAT_O, q;
  pss_pkg::pss_cond_s COND = '0;
  logic [6:0] pc = '0;
  logic pend = 0, rf = 0;
  int miscompares = 0, tests_run = 0;
  always #5 CLOCK = ~CLOCK;
  pss_status_regs pss_status_regs_i (.CLOCK(CLOCK), .NRST(NRST), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
    .COND(COND), .DAT_O(DAT_O), .ACK_O(ACK_O), .IRQ(IRQ));
  pss_host pss_host_i (.CLOCK(CLOCK), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O));
  task automatic end_sim();
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // ----------------------------------------------------------------
  // Model updates
  // ----------------------------------------------------------------
  task automatic set_cond(logic [6:0] c);
    pend |= (c[0] != pc[0]) | (c[4] & ~pc[4]) | (c[6] & ~pc[6]) | (c[5] & ~pc[5]);
    rf |= c[6];
    pc = c;
    @(posedge CLOCK);
    COND <= c;
    repeat (3) @(posedge CLOCK);
    chk("irq", {31'h0, pend}, {31'h0, IRQ});
  endtask
  task automatic rd_status();
    pss_host_i.xfer(1'b0, 10'h040, 32'h0, q);
    chk("status", {24'h0, pend, rf, pc[5:0]}, q);
  endtask
  task automatic rd_basic();
    pss_host_i.xfer(1'b0, 10'h004, 32'h0, q);
    chk("basic", {26'h0, pc[4], rf, 1'h0, pc[0], pc[5], 1'h0}, q);
    rf = pc[6];
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CLOCK);
    NRST <= 1'b1;
    void'($urandom(93009));
    rd_status();
    pss_host_i.xfer(1'b1, 10'h040, 32'hFFFF, q);
    rd_status();
    pss_host_i.xfer(1'b0, 10'h3FC, 32'h0, q);
    chk("unmapped", 32'h0, q);
    pss_host_i.xfer(1'b1, 10'h04C, 32'hF, q);
    pss_host_i.xfer(1'b0, 10'h04C, 32'h0, q);
    chk("mask", 32'hF, q);
    set_cond(7'h40);
    set_cond(7'h00);
    rd_status();
    rd_basic();
    rd_status();
    for (int i = 0; i < 40; i++) begin
      set_cond(7'($urandom));
      rd_status();
      rd_status();
      if (i % 2 == 1) begin
        pss_host_i.xfer(1'b0, 10'h048, 32'h0, q);
        pend = 0;
        rd_status();
      end
      if (i % 5 == 0) begin
        rd_basic();
        rd_status();
      end
    end
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge CLOCK);
    miscompares++;
    end_sim();
  end
endmodule
